// [upel_pkg.sv]
// Package of constants and carrier types for the USB PHY event latch block.
`default_nettype none
package upel_pkg;
	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam logic [7:0] ADDR_RISE_WR   = 8'h0d;
	localparam logic [7:0] ADDR_RISE_SET  = 8'h0e;
	localparam logic [7:0] ADDR_RISE_CLR  = 8'h0f;
	localparam logic [7:0] ADDR_FALL_WR   = 8'h10;
	localparam logic [7:0] ADDR_FALL_SET  = 8'h11;
	localparam logic [7:0] ADDR_FALL_CLR  = 8'h12;
	localparam logic [7:0] ADDR_STATUS    = 8'h13;
	localparam logic [7:0] ADDR_LATCH     = 8'h14;
	// ***************************************************************
	// Field layout and reset values
	// ***************************************************************
	localparam int         NUM_SRC        = 4;
	localparam logic [7:0] ENABLE_RESET   = 8'h1f;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;
	localparam logic [3:0] ZERO_SRC       = 4'h0;
	localparam int         BIT_SESSION_END   = 3;
	localparam int         BIT_SESS_VALID = 2;
	localparam int         BIT_VBUS_VALID = 1;
	localparam int         BIT_HOST_DISC  = 0;
	// ***************************************************************
	// Carrier types
	// ***************************************************************
	typedef struct packed {
		logic session_end;
		logic session_valid_signal;
		logic vbus_valid_signal;
		logic host_disconnect;
	} upel_src_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} upel_req_t;
	typedef enum logic [1:0] {
		UPEL_ACTIVE    = 2'b01,
		UPEL_LOW_POWER = 2'b10
	} upel_pwr_t;
endpackage
`default_nettype wire

// [upel_event_latch.sv]
// Event enable, status and sticky latch logic of the USB PHY event latch block.
//
// The plain strobed port is this design's own decision.
`default_nettype none
module upel_event_latch (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire upel_pkg::upel_req_t req,
	output logic [7:0]               rdata,
	input  wire upel_pkg::upel_src_t src_async,
	input  wire logic                low_power,
	output logic                     event_irq,
	output logic                     rxcmd_req,
	output upel_pkg::upel_src_t      rxcmd_src
);
	import upel_pkg::*;

	// ***************************************************************
	// Source synchroniser and edge detection
	// ***************************************************************
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] prev;
	logic [3:0] rise_en;
	logic [3:0] fall_en;
	logic [3:0] latch;
	logic [7:0] rise_reg;
	logic [7:0] fall_reg;
	upel_pwr_t  pwr;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_a <= ZERO_SRC;
			sync_b <= ZERO_SRC;
			prev   <= ZERO_SRC;
		end else begin
			sync_a <= src_async;
			sync_b <= sync_a;
			prev   <= sync_b;
		end
	end

	logic [3:0] rise_evt;
	logic [3:0] fall_evt;
	logic [3:0] any_evt;
	assign rise_en = rise_reg[NUM_SRC-1:0];
	assign fall_en = fall_reg[NUM_SRC-1:0];

	// Each source has a detector of its own, so the enables gate bit by bit.
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_edge
		assign rise_evt[i] = sync_b[i] && !prev[i] && rise_en[i];
		assign fall_evt[i] = !sync_b[i] && prev[i] && fall_en[i];
	end
	assign any_evt  = rise_evt | fall_evt;

	// ***************************************************************
	// Enable registers
	// ***************************************************************
	function automatic logic [7:0] upel_wsc(input logic [7:0] cur, input upel_req_t r,
		input logic [7:0] a_wr, input logic [7:0] a_set, input logic [7:0] a_clr);
		logic [7:0] v;
		v = cur;
		if (r.wr && r.addr == a_wr) begin
			v = r.wdata;
		end else if (r.wr && r.addr == a_set) begin
			v = cur | r.wdata;
		end else if (r.wr && r.addr == a_clr) begin
			v = cur & ~r.wdata;
		end
		return v;
	endfunction

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fall_reg <= ENABLE_RESET;
		end else begin
			fall_reg <= upel_wsc(fall_reg, req, ADDR_FALL_WR, ADDR_FALL_SET, ADDR_FALL_CLR);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rise_reg <= ENABLE_RESET;
		end else begin
			rise_reg <= upel_wsc(rise_reg, req, ADDR_RISE_WR, ADDR_RISE_SET, ADDR_RISE_CLR);
		end
	end

	// ***************************************************************
	// Power state and sticky latch
	// ***************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwr <= UPEL_ACTIVE;
		end else begin
			case (pwr)
				UPEL_ACTIVE:    pwr <= low_power ? UPEL_LOW_POWER : UPEL_ACTIVE;
				UPEL_LOW_POWER: pwr <= low_power ? UPEL_LOW_POWER : UPEL_ACTIVE;
				default:        pwr <= UPEL_ACTIVE;
			endcase
		end
	end

	logic lp_entry;
	logic latch_rd;
	assign lp_entry = low_power && pwr == UPEL_ACTIVE;
	assign latch_rd = req.rd && req.addr == ADDR_LATCH;

	// A new event in the clearing cycle survives: set wins over clear.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			latch <= ZERO_SRC;
		end else if (latch_rd || lp_entry) begin
			latch <= any_evt;
		end else begin
			latch <= latch | any_evt;
		end
	end

	// ***************************************************************
	// Event outputs
	// ***************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			event_irq <= 1'b0;
			rxcmd_req <= 1'b0;
			rxcmd_src <= upel_src_t'(ZERO_SRC);
		end else begin
			event_irq <= |any_evt;
			rxcmd_req <= |any_evt;
			rxcmd_src <= sync_b;
		end
	end

	// ***************************************************************
	// Register read port
	// ***************************************************************
	logic [7:0] next_rdata;
	logic       rd_rise_hit;
	logic       rd_fall_hit;
	assign rd_rise_hit = req.addr >= ADDR_RISE_WR && req.addr <= ADDR_RISE_CLR;
	assign rd_fall_hit = req.addr >= ADDR_FALL_WR && req.addr <= ADDR_FALL_CLR;

	// Idle cycles and unmapped addresses read as zero, so stale data never lingers on the port.
	always_comb begin
		next_rdata = ZERO_BYTE;
		if (req.rd) begin
			if (rd_rise_hit) begin
				next_rdata = rise_reg;
			end else if (rd_fall_hit) begin
				next_rdata = fall_reg;
			end else if (req.addr == ADDR_STATUS) begin
				next_rdata = {ZERO_SRC, sync_b};
			end else if (latch_rd) begin
				next_rdata = {ZERO_SRC, latch};
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata <= ZERO_BYTE;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	sequence s_fall_seen;
		prev[BIT_SESSION_END] && !sync_b[BIT_SESSION_END] && fall_reg[BIT_SESSION_END];
	endsequence

	chk_fall_irq_out: assert property (@(posedge clk) disable iff (sys_rst)
		s_fall_seen |=> event_irq && rxcmd_req)
		else $error("enabled fall gave no event");
	chk_enable_reset: assert property (@(posedge clk)
		$fell(sys_rst) |-> fall_reg == ENABLE_RESET && rise_reg == ENABLE_RESET)
		else $error("enable reset value wrong");
	chk_fall_set_op: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == ADDR_FALL_SET |=> fall_reg == ($past(fall_reg) | $past(req.wdata)))
		else $error("set address did not OR");
	chk_fall_clr_op: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == ADDR_FALL_CLR |=> fall_reg == ($past(fall_reg) & ~$past(req.wdata)))
		else $error("clear address did not clear");
	chk_status_read: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == ADDR_STATUS |=> rdata == {4'h0, $past(sync_b)})
		else $error("status read mismatch");
	chk_masked_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!latch_rd && !lp_entry && any_evt == ZERO_SRC |=> latch == $past(latch))
		else $error("latch changed without event");
	chk_latch_rdclr: assert property (@(posedge clk) disable iff (sys_rst)
		latch_rd && any_evt == ZERO_SRC |=> latch == ZERO_SRC)
		else $error("latch read did not clear");
	chk_lp_clear: assert property (@(posedge clk) disable iff (sys_rst)
		lp_entry && any_evt == ZERO_SRC |=> latch == ZERO_SRC)
		else $error("low power did not clear latch");
	chk_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |-> ##2 sync_b == $past(src_async, 2))
		else $error("synchroniser delay wrong");
	chk_rise_event: assert property (@(posedge clk) disable iff (sys_rst)
		!prev[BIT_HOST_DISC] && sync_b[BIT_HOST_DISC] && rise_reg[BIT_HOST_DISC] |=> event_irq)
		else $error("enabled rise gave no event");

	// ***************************************************************
	// Register port checks
	// ***************************************************************
	sequence s_fall_read;
		req.rd && req.addr >= ADDR_FALL_WR && req.addr <= ADDR_FALL_CLR;
	endsequence

	sequence s_rise_read;
		req.rd && req.addr >= ADDR_RISE_WR && req.addr <= ADDR_RISE_CLR;
	endsequence

	sequence s_latch_read;
		req.rd && req.addr == ADDR_LATCH;
	endsequence

	chk_fall_rd_data: assert property (@(posedge clk) disable iff (sys_rst)
		s_fall_read |=> rdata == $past(fall_reg))
		else $error("falling enable read mismatch");

	chk_rise_rd_data: assert property (@(posedge clk) disable iff (sys_rst)
		s_rise_read |=> rdata == $past(rise_reg))
		else $error("rising enable read mismatch");

	chk_latch_rd_data: assert property (@(posedge clk) disable iff (sys_rst)
		s_latch_read |=> rdata == {ZERO_SRC, $past(latch)})
		else $error("latch read mismatch");

	chk_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!req.rd |=> rdata == ZERO_BYTE)
		else $error("read data not zero when idle");

	chk_unmapped_rd: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && (req.addr < ADDR_RISE_WR || req.addr > ADDR_LATCH) |=> rdata == ZERO_BYTE)
		else $error("unmapped read not zero");

	chk_fall_wr_op: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == ADDR_FALL_WR |=> fall_reg == $past(req.wdata))
		else $error("falling enable write failed");

	chk_rise_wr_op: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == ADDR_RISE_WR |=> rise_reg == $past(req.wdata))
		else $error("rising enable write failed");

	chk_rise_set_op: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == ADDR_RISE_SET |=> rise_reg == ($past(rise_reg) | $past(req.wdata)))
		else $error("rising set address did not OR");

	chk_rise_clr_op: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && req.addr == ADDR_RISE_CLR |=> rise_reg == ($past(rise_reg) & ~$past(req.wdata)))
		else $error("rising clear address did not clear");

	chk_fall_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.wr && req.addr >= ADDR_FALL_WR && req.addr <= ADDR_FALL_CLR) |=> $stable(fall_reg))
		else $error("falling enable changed without write");

	chk_rise_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.wr && req.addr >= ADDR_RISE_WR && req.addr <= ADDR_RISE_CLR) |=> $stable(rise_reg))
		else $error("rising enable changed without write");

	// ***************************************************************
	// Event and latch checks
	// ***************************************************************
	sequence s_any_edge;
		any_evt != ZERO_SRC;
	endsequence

	sequence s_no_edge;
		any_evt == ZERO_SRC;
	endsequence

	sequence s_fall_masked;
		prev[BIT_SESS_VALID] && !sync_b[BIT_SESS_VALID] && !fall_reg[BIT_SESS_VALID];
	endsequence

	sequence s_rise_masked;
		!prev[BIT_VBUS_VALID] && sync_b[BIT_VBUS_VALID] && !rise_reg[BIT_VBUS_VALID];
	endsequence

	chk_irq_pair: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |-> event_irq == rxcmd_req)
		else $error("interrupt and command pulses differ");

	chk_edge_notify: assert property (@(posedge clk) disable iff (sys_rst)
		s_any_edge |=> event_irq && rxcmd_req)
		else $error("enabled edge gave no notification");

	chk_quiet_no_edge: assert property (@(posedge clk) disable iff (sys_rst)
		s_no_edge |=> !event_irq && !rxcmd_req)
		else $error("notification without enabled edge");

	chk_latch_set: assert property (@(posedge clk) disable iff (sys_rst)
		s_any_edge |=> (latch & $past(any_evt)) == $past(any_evt))
		else $error("enabled edge not latched");

	chk_fall_masked: assert property (@(posedge clk) disable iff (sys_rst)
		s_fall_masked |-> !any_evt[BIT_SESS_VALID])
		else $error("masked fall raised an event");

	chk_rise_masked: assert property (@(posedge clk) disable iff (sys_rst)
		s_rise_masked |-> !any_evt[BIT_VBUS_VALID])
		else $error("masked rise raised an event");

	chk_src_copy: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> rxcmd_src == $past(sync_b))
		else $error("command source copy wrong");

	chk_lp_state: assert property (@(posedge clk) disable iff (sys_rst)
		low_power |=> pwr == UPEL_LOW_POWER)
		else $error("low power state not entered");

	chk_lp_exit: assert property (@(posedge clk) disable iff (sys_rst)
		!low_power |=> pwr == UPEL_ACTIVE)
		else $error("low power state not left");

	chk_latch_keep: assert property (@(posedge clk) disable iff (sys_rst)
		!latch_rd && !lp_entry |=> (latch & $past(latch)) == $past(latch))
		else $error("latch bit lost without clear");

	chk_sync_order: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> prev == $past(sync_b))
		else $error("edge reference stage wrong");

	chk_end_fall_latch: assert property (@(posedge clk) disable iff (sys_rst)
		s_fall_seen |=> latch[BIT_SESSION_END])
		else $error("session end fall not latched");

	chk_host_rise_latch: assert property (@(posedge clk) disable iff (sys_rst)
		!prev[BIT_HOST_DISC] && sync_b[BIT_HOST_DISC] && rise_reg[BIT_HOST_DISC] |=> latch[BIT_HOST_DISC])
		else $error("disconnect rise not latched");
endmodule
`default_nettype wire

// [upel_link_model.sv]
// Link-side model that counts the event notifications sent by the block.
`default_nettype none
module upel_link_model (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                event_irq,
	input  wire logic                rxcmd_req,
	input  wire upel_pkg::upel_src_t rxcmd_src,
	output int                       n_cmd,
	output int                       n_irq,
	output logic [3:0]               last_src
);
	timeunit 1ns;
	timeprecision 1ps;
	import upel_pkg::*;
	// The link never reads the latch and relies on the notifications alone.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			n_cmd <= 0;
			n_irq <= 0;
			last_src <= 4'h0;
		end else begin
			if (rxcmd_req) n_cmd <= n_cmd + 1;
			if (event_irq) n_irq <= n_irq + 1;
			if (rxcmd_req) last_src <= rxcmd_src;
		end
	end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the USB PHY event latch block.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import upel_pkg::*;
	logic        clk, sys_rst, low_power, event_irq, rxcmd_req;
	upel_req_t   req;
	upel_src_t   src, rxcmd_src;
	logic [7:0]  rdata, d, fe, re, lat;
	logic [3:0]  p, s, ev, last_src;
	logic [31:0] seed = 32'h3e;
	int          mismatches, cmp_count, n_cmd, n_irq, exp_cmd;
	upel_event_latch uut (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
		.src_async(src), .low_power(low_power), .event_irq(event_irq),
		.rxcmd_req(rxcmd_req), .rxcmd_src(rxcmd_src));
	upel_link_model link (.clk(clk), .sys_rst(sys_rst), .event_irq(event_irq),
		.rxcmd_req(rxcmd_req), .rxcmd_src(rxcmd_src), .n_cmd(n_cmd), .n_irq(n_irq),
		.last_src(last_src));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rdchk(string n, logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask
	// Applies a new source value and predicts latch bits and notifications.
	task automatic step(logic [3:0] nv);
		p = s;
		s = nv;
		ev = (p & ~s & fe[3:0]) | (~p & s & re[3:0]);
		lat[3:0] |= ev;
		if (ev != 4'h0) exp_cmd++;
		@(posedge clk);
		src <= upel_src_t'(s);
		repeat (5) @(posedge clk);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#1ms;
		mismatches++;
		finish_test();
	end
	initial begin
		sys_rst = 1'b1;
		low_power = 1'b0;
		req = '0;
		src = '0;
		s = 4'h0;
		lat = 8'h00;
		fe = ENABLE_RESET;
		re = ENABLE_RESET;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk("fall_en_w", ADDR_FALL_WR, ENABLE_RESET);
		rdchk("fall_en_s", ADDR_FALL_SET, ENABLE_RESET);
		rdchk("fall_en_c", ADDR_FALL_CLR, ENABLE_RESET);
		rdchk("rise_en", ADDR_RISE_CLR, ENABLE_RESET);
		rdchk("status", ADDR_STATUS, ZERO_BYTE);
		rdchk("latch", ADDR_LATCH, ZERO_BYTE);
		rdchk("unmapped", 8'h20, ZERO_BYTE);
		step(4'hf);
		rdchk("latch_rise", ADDR_LATCH, lat);
		step(4'h0);
		rdchk("latch_fall", ADDR_LATCH, 8'h0f);
		lat = 8'h00;
		for (int i = 0; i < 24; i++) begin
			wr(ADDR_FALL_WR, 8'h00);
			fe = 8'(xs());
			wr(ADDR_FALL_SET, fe);
			d = 8'(xs());
			wr(ADDR_FALL_CLR, d);
			fe &= ~d;
			rdchk("fall_en", ADDR_FALL_SET, fe);
			re = 8'(xs());
			wr(ADDR_RISE_WR, re);
			step(4'(xs()));
			rdchk("status", ADDR_STATUS, {4'h0, s});
			if (ev != 4'h0) chk("rxcmd_src", {4'h0, s}, {4'h0, last_src});
			chk("rxcmd_count", 8'(exp_cmd), 8'(n_cmd));
			chk("irq_count", 8'(exp_cmd), 8'(n_irq));
			rdchk("latch", ADDR_LATCH, lat);
			lat = 8'h00;
			rdchk("latch_clr", ADDR_LATCH, ZERO_BYTE);
		end
		wr(ADDR_FALL_WR, 8'hff);
		fe = 8'hff;
		wr(ADDR_RISE_WR, 8'hff);
		re = 8'hff;
		step(~s);
		chk("rxcmd_lp", 8'(exp_cmd), 8'(n_cmd));
		low_power <= 1'b1;
		repeat (2) @(posedge clk);
		rdchk("latch_lp", ADDR_LATCH, ZERO_BYTE);
		low_power <= 1'b0;
		finish_test();
	end
endmodule
`default_nettype wire
